// >>> src/eca_map.vh
// Constants of the eight-bit execution core: functions, operand kinds, SFRs, timing
`ifndef ECA_MAP_VH
`define ECA_MAP_VH

// ALU function codes
`define ECA_F_PASS 5'h00
`define ECA_F_ADD 5'h01
`define ECA_F_ADD_WITH_CARRY_OP 5'h02
`define ECA_F_SUBTRACT_WITH_BORROW_OP 5'h03
`define ECA_F_INC 5'h04
`define ECA_F_DEC 5'h05
`define ECA_F_AND 5'h06
`define ECA_F_OR 5'h07
`define ECA_F_XOR 5'h08
`define ECA_F_CLR 5'h09
`define ECA_F_CPL 5'h0A
`define ECA_F_RL 5'h0B
`define ECA_F_RLC 5'h0C
`define ECA_F_RR 5'h0D
`define ECA_F_RRC 5'h0E
`define ECA_F_SWAP 5'h0F
`define ECA_F_MUL 5'h10
`define ECA_F_DIV 5'h11
`define ECA_F_DA 5'h12
`define ECA_F_SETB 5'h13
`define ECA_F_CLRB 5'h14
`define ECA_F_CPLB 5'h15
`define ECA_F_CLRC 5'h16
`define ECA_F_SETC 5'h17
`define ECA_F_CPLC 5'h18

// Operand location kinds
`define ECA_K_NONE 4'h0
`define ECA_K_ACC 4'h1
`define ECA_K_REG 4'h2
`define ECA_K_DIR 4'h3
`define ECA_K_DIR2 4'h4
`define ECA_K_IND 4'h5
`define ECA_K_IMM 4'h6
`define ECA_K_IMM2 4'h7
`define ECA_K_XD 4'h8
`define ECA_K_PM 4'h9
`define ECA_K_BIT 4'hA
`define ECA_K_DATA_POINTER_REGISTER 4'hB
`define ECA_K_B 4'hC

// Special function register addresses in the direct space
`define ECA_SFR_ACC 8'hE0
`define ECA_SFR_B 8'hF0
`define ECA_SFR_PSW 8'hD0
`define ECA_SFR_DPL 8'h82
`define ECA_SFR_DPH 8'h83

// Status word field positions
`define ECA_PSW_CY 7
`define ECA_PSW_AC 6
`define ECA_PSW_OV 2
`define ECA_PSW_RS_HI 4
`define ECA_PSW_RS_LO 3

// Bit space: low half lives in bytes 20h..2Fh
`define ECA_BIT_BASE_HI 4'h2

// Reset values
`define ECA_RST_PC 16'h0000
`define ECA_RST_BYTE 8'h00
`define ECA_RST_PSW 7'h00
`define ECA_RST_DATA_POINTER_REGISTER 16'h0000

// Cycle counts, in CPU clocks from the opcode fetch
`define ECA_CYC_REG 3'h1
`define ECA_CYC_DIR 3'h2
`define ECA_CYC_IND 3'h2
`define ECA_CYC_IMM 3'h2
`define ECA_CYC_INC_REG 3'h2
`define ECA_CYC_INC_MEM 3'h3
`define ECA_CYC_LOG_DIR 3'h3
`define ECA_CYC_MOV3 3'h3
`define ECA_CYC_MUL 3'h2
`define ECA_CYC_DIV 3'h6
`define ECA_CYC_DA 3'h3
`define ECA_CYC_MOVC 3'h5
`define ECA_CYC_XRD_DP 3'h3
`define ECA_CYC_XRD_RI 3'h4
`define ECA_CYC_XWR_DP 3'h4
`define ECA_CYC_XWR_RI 3'h5
`define ECA_CYC_BIT 3'h3

`endif

// >>> src/eca_alu.v
// Combinational arithmetic and logic unit of the eight-bit execution core
`timescale 1ns/100ps
`include "eca_map.vh"

module eca_alu
(
  input wire [4:0] fn,
  input wire [7:0] x,
  input wire [7:0] y,
  input wire cin,
  input wire acin,
  output reg [7:0] res,
  output reg [7:0] res_hi,
  output reg cy,
  output reg ac,
  output reg ov,
  output reg wr_cy,
  output reg wr_acov
);

  reg [8:0] sum;     // Nine-bit sum or difference
  reg [4:0] nib;     // Low nibble sum or difference, for aux carry
  reg [15:0] prod;   // Product of x and y
  reg [8:0] adj;     // Decimal adjust working value
  reg [7:0] mask;    // One-hot bit select

  // All functions evaluated in parallel, result picked by fn
  always @*
  begin
    sum = 9'h000;
    nib = 5'h00;
    prod = x * y;
    adj = {1'b0, x};
    mask = 8'h01 << y[2:0];
    res = y;
    res_hi = 8'h00;
    cy = cin;
    ac = acin;
    ov = 1'b0;
    wr_cy = 1'b0;
    wr_acov = 1'b0;
    case (fn)
      `ECA_F_ADD, `ECA_F_ADD_WITH_CARRY_OP:
      begin
        // Carry joins the sum only for the with-carry form
        sum = {1'b0, x} + {1'b0, y} + {8'h00, (fn == `ECA_F_ADD_WITH_CARRY_OP) & cin};
        nib = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, (fn == `ECA_F_ADD_WITH_CARRY_OP) & cin};
        res = sum[7:0];
        cy = sum[8];
        ac = nib[4];
        ov = (x[7] == y[7]) && (sum[7] != x[7]);
        wr_cy = 1'b1;
        wr_acov = 1'b1;
      end
      `ECA_F_SUBTRACT_WITH_BORROW_OP:
      begin
        // Source operand and carry-flag borrow both come off the accumulator
        sum = {1'b0, x} - {1'b0, y} - {8'h00, cin};
        nib = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
        res = sum[7:0];
        cy = sum[8];
        ac = nib[4];
        ov = (x[7] != y[7]) && (sum[7] != x[7]);
        wr_cy = 1'b1;
        wr_acov = 1'b1;
      end
      `ECA_F_INC: res = x + 8'h01;
      `ECA_F_DEC: res = x - 8'h01;
      // AND, OR and XOR: each result bit from the matching operand bits only
      `ECA_F_AND: res = x & y;
      `ECA_F_OR: res = x | y;
      `ECA_F_XOR: res = x ^ y;
      `ECA_F_CLR: res = 8'h00;
      `ECA_F_CPL: res = ~x;
      `ECA_F_RL: res = {x[6:0], x[7]};
      `ECA_F_RR: res = {x[0], x[7:1]};
      `ECA_F_RLC:
      begin
        res = {x[6:0], cin};
        cy = x[7];
        wr_cy = 1'b1;
      end
      `ECA_F_RRC:
      begin
        res = {cin, x[7:1]};
        cy = x[0];
        wr_cy = 1'b1;
      end
      `ECA_F_SWAP: res = {x[3:0], x[7:4]};
      `ECA_F_MUL:
      begin
        // Low byte to accumulator, high byte to B
        res = prod[7:0];
        res_hi = prod[15:8];
        cy = 1'b0;
        ov = (prod[15:8] != 8'h00);
        wr_cy = 1'b1;
        wr_acov = 1'b1;
      end
      `ECA_F_DIV:
      begin
        // Divide by zero leaves both bytes alone and flags overflow
        res = (y == 8'h00) ? x : x / y;
        res_hi = (y == 8'h00) ? y : x % y;
        cy = 1'b0;
        ov = (y == 8'h00);
        wr_cy = 1'b1;
        wr_acov = 1'b1;
      end
      `ECA_F_DA:
      begin
        if ((x[3:0] > 4'h9) || acin)
          adj = adj + 9'h006;
        if ((adj[7:4] > 4'h9) || adj[8] || cin)
          adj = adj + 9'h060;
        res = adj[7:0];
        cy = adj[8] | cin;
        wr_cy = 1'b1;
      end
      // Single bit of a byte, index in y
      `ECA_F_SETB: res = x | mask;
      `ECA_F_CLRB: res = x & ~mask;
      `ECA_F_CPLB: res = x ^ mask;
      `ECA_F_CLRC:
      begin
        cy = 1'b0;
        wr_cy = 1'b1;
      end
      `ECA_F_SETC:
      begin
        cy = 1'b1;
        wr_cy = 1'b1;
      end
      `ECA_F_CPLC:
      begin
        cy = ~cin;
        wr_cy = 1'b1;
      end
      default: res = y;
    endcase
  end

endmodule

// >>> src/eca_core.v
// Execution core: operand addressing, instruction timing and register state
`timescale 1ns/100ps
`include "eca_map.vh"

module eca_core
(
  input wire CORE_CLK,
  input wire RST,
  output wire [15:0] PM_ADDR,
  input wire [7:0] PM_DATA,
  output reg [15:0] XD_ADDR,
  output reg XD_RD,
  output reg XD_WE,
  output reg [7:0] XD_WDATA,
  input wire [7:0] XD_RDATA,
  output reg [15:0] PC,
  output reg [7:0] ACC,
  output reg [7:0] B_REG,
  output wire [7:0] PSW,
  output reg [15:0] DATA_POINTER_REGISTER,
  output reg INSTR_DONE,
  output reg BAD_OPCODE
);

  reg [7:0] iram [0:255];  // Internal RAM, upper half reached only indirectly
  reg [2:0] cnt;           // Cycle of the current instruction, 1 = opcode fetch
  reg [7:0] opc_q;         // Held opcode
  reg [7:0] arg1_q;        // Held second byte
  reg [7:0] arg2_q;        // Held third byte
  reg [7:1] psw_q;         // Stored status bits, parity is live

  reg [1:0] len;           // Instruction length in bytes
  reg [2:0] cyc;           // Instruction length in cycles
  reg [4:0] fn;            // ALU function
  reg [3:0] src;           // Source operand kind
  reg [3:0] dst;           // Destination operand kind
  reg known;               // Opcode is implemented
  reg [7:0] x;             // Destination-side operand value
  reg [7:0] y;             // Source-side operand value

  wire [7:0] alu_res;
  wire [7:0] alu_hi;
  wire alu_cy;
  wire alu_ac;
  wire alu_ov;
  wire wr_cy;
  wire wr_acov;

  // Bytes of the current instruction, live while being fetched
  wire [7:0] opc = (cnt == 3'h1) ? PM_DATA : opc_q;
  wire [7:0] arg1 = (cnt == 3'h2) ? PM_DATA : arg1_q;
  wire [7:0] arg2 = (cnt == 3'h3) ? PM_DATA : arg2_q;

  wire fetch = (cnt <= {1'b0, len});
  wire last = (cnt == cyc);
  wire pre_last = (cnt + 3'h1 == cyc);

  // Working register and pointer addresses in the selected bank
  wire [7:0] reg_addr = {3'h0, psw_q[`ECA_PSW_RS_HI:`ECA_PSW_RS_LO], opc[2:0]};
  wire [7:0] ri_val = iram[{3'h0, psw_q[`ECA_PSW_RS_HI:`ECA_PSW_RS_LO], 2'h0, opc[0]}];
  // Bits 0..127 sit in RAM bytes 20h..2Fh, the rest in SPECIAL_FUNCTION_REGISTER bytes at multiples of 8
  wire [7:0] bit_addr = arg1[7] ? {arg1[7:3], 3'h0} : {`ECA_BIT_BASE_HI, arg1[6:3]};

  wire [8:0] s_loc;        // Source: {is SPECIAL_FUNCTION_REGISTER, byte address}
  wire [8:0] d_loc;        // Destination: {is SPECIAL_FUNCTION_REGISTER, byte address}
  wire [7:0] s_byte;
  wire [7:0] d_byte;

  // Parity follows the accumulator at all times
  assign PSW = {psw_q, ^ACC};

  // Indexed code read after the fetch bytes, program counter otherwise
  assign PM_ADDR = (fetch || (src != `ECA_K_PM)) ? PC : DATA_POINTER_REGISTER + {8'h00, ACC};

  // Resolve a location kind to a byte address; direct upper half is SPECIAL_FUNCTION_REGISTER space
  function [8:0] eca_loc;
    input [3:0] k;
    input [7:0] rega;
    input [7:0] ria;
    input [7:0] a1;
    input [7:0] a2;
    input [7:0] bita;
    begin
      case (k)
        `ECA_K_REG: eca_loc = {1'b0, rega};
        `ECA_K_IND: eca_loc = {1'b0, ria};
        `ECA_K_DIR: eca_loc = {a1[7], a1};
        `ECA_K_DIR2: eca_loc = {a2[7], a2};
        `ECA_K_BIT: eca_loc = {bita[7], bita};
        default: eca_loc = 9'h000;
      endcase
    end
  endfunction

  // Special function register read; unmapped ones read as zero
  function [7:0] eca_sfr;
    input [7:0] a;
    input [7:0] acc;
    input [7:0] b;
    input [7:0] psw;
    input [15:0] dp;
    begin
      case (a)
        `ECA_SFR_ACC: eca_sfr = acc;
        `ECA_SFR_B: eca_sfr = b;
        `ECA_SFR_PSW: eca_sfr = psw;
        `ECA_SFR_DPL: eca_sfr = dp[7:0];
        `ECA_SFR_DPH: eca_sfr = dp[15:8];
        default: eca_sfr = 8'h00;
      endcase
    end
  endfunction

  // Row of the arithmetic and logic groups to ALU function
  function [4:0] eca_row_fn;
    input [3:0] hi;
    begin
      case (hi)
        4'h2: eca_row_fn = `ECA_F_ADD;
        4'h3: eca_row_fn = `ECA_F_ADD_WITH_CARRY_OP;
        4'h9: eca_row_fn = `ECA_F_SUBTRACT_WITH_BORROW_OP;
        4'h4: eca_row_fn = `ECA_F_OR;
        4'h5: eca_row_fn = `ECA_F_AND;
        4'h6: eca_row_fn = `ECA_F_XOR;
        default: eca_row_fn = `ECA_F_PASS;
      endcase
    end
  endfunction

  assign s_loc = eca_loc(src, reg_addr, ri_val, arg1, arg2, bit_addr);
  assign d_loc = eca_loc(dst, reg_addr, ri_val, arg1, arg2, bit_addr);
  assign s_byte = s_loc[8] ? eca_sfr(s_loc[7:0], ACC, B_REG, PSW, DATA_POINTER_REGISTER) : iram[s_loc[7:0]];
  assign d_byte = d_loc[8] ? eca_sfr(d_loc[7:0], ACC, B_REG, PSW, DATA_POINTER_REGISTER) : iram[d_loc[7:0]];

  // Opcode decode: length, cycle count, function and operand kinds
  always @*
  begin
    len = 2'h1;
    cyc = `ECA_CYC_REG;
    fn = `ECA_F_PASS;
    src = `ECA_K_NONE;
    dst = `ECA_K_NONE;
    known = 1'b1;
    case (opc)
      8'h00: known = 1'b1;  // No operation
      // Accumulator-only forms carry no operand field
      8'h03: begin dst = `ECA_K_ACC; fn = `ECA_F_RR; end
      8'h13: begin dst = `ECA_K_ACC; fn = `ECA_F_RRC; end
      8'h23: begin dst = `ECA_K_ACC; fn = `ECA_F_RL; end
      8'h33: begin dst = `ECA_K_ACC; fn = `ECA_F_RLC; end
      8'hC4: begin dst = `ECA_K_ACC; fn = `ECA_F_SWAP; end
      8'hE4: begin dst = `ECA_K_ACC; fn = `ECA_F_CLR; end
      8'hF4: begin dst = `ECA_K_ACC; fn = `ECA_F_CPL; end
      8'h04: begin dst = `ECA_K_ACC; fn = `ECA_F_INC; end
      8'h14: begin dst = `ECA_K_ACC; fn = `ECA_F_DEC; end
      8'hD4: begin dst = `ECA_K_ACC; fn = `ECA_F_DA; cyc = `ECA_CYC_DA; end
      8'h05, 8'h15:
      begin
        len = 2'h2;
        cyc = `ECA_CYC_INC_MEM;
        dst = `ECA_K_DIR;
        fn = opc[4] ? `ECA_F_DEC : `ECA_F_INC;
      end
      8'h06, 8'h07, 8'h16, 8'h17:
      begin
        cyc = `ECA_CYC_INC_MEM;
        dst = `ECA_K_IND;
        fn = opc[4] ? `ECA_F_DEC : `ECA_F_INC;
      end
      8'h42, 8'h52, 8'h62, 8'h43, 8'h53, 8'h63:
      begin
        // Logic into a direct byte, from accumulator or immediate
        len = opc[0] ? 2'h3 : 2'h2;
        cyc = `ECA_CYC_LOG_DIR;
        dst = `ECA_K_DIR;
        src = opc[0] ? `ECA_K_IMM2 : `ECA_K_ACC;
        fn = eca_row_fn(opc[7:4]);
      end
      8'h74: begin len = 2'h2; cyc = `ECA_CYC_IMM; dst = `ECA_K_ACC; src = `ECA_K_IMM; end
      8'h75: begin len = 2'h3; cyc = `ECA_CYC_MOV3; dst = `ECA_K_DIR; src = `ECA_K_IMM2; end
      8'h76, 8'h77: begin len = 2'h2; cyc = `ECA_CYC_IMM; dst = `ECA_K_IND; src = `ECA_K_IMM; end
      // Direct to direct: source address first, then destination
      8'h85: begin len = 2'h3; cyc = `ECA_CYC_MOV3; dst = `ECA_K_DIR2; src = `ECA_K_DIR; end
      8'hF5: begin len = 2'h2; cyc = `ECA_CYC_DIR; dst = `ECA_K_DIR; src = `ECA_K_ACC; end
      8'hF6, 8'hF7: begin cyc = `ECA_CYC_IND; dst = `ECA_K_IND; src = `ECA_K_ACC; end
      8'hA4: begin cyc = `ECA_CYC_MUL; dst = `ECA_K_ACC; src = `ECA_K_B; fn = `ECA_F_MUL; end
      8'h84: begin cyc = `ECA_CYC_DIV; dst = `ECA_K_ACC; src = `ECA_K_B; fn = `ECA_F_DIV; end
      8'h90: begin len = 2'h3; cyc = `ECA_CYC_MOV3; dst = `ECA_K_DATA_POINTER_REGISTER; end
      8'hA3: dst = `ECA_K_DATA_POINTER_REGISTER;
      8'h93: begin cyc = `ECA_CYC_MOVC; dst = `ECA_K_ACC; src = `ECA_K_PM; end
      // External data: accumulator on one side, indirect address only
      8'hE0: begin cyc = `ECA_CYC_XRD_DP; dst = `ECA_K_ACC; src = `ECA_K_XD; end
      8'hE2, 8'hE3: begin cyc = `ECA_CYC_XRD_RI; dst = `ECA_K_ACC; src = `ECA_K_XD; end
      8'hF0: begin cyc = `ECA_CYC_XWR_DP; dst = `ECA_K_XD; src = `ECA_K_ACC; end
      8'hF2, 8'hF3: begin cyc = `ECA_CYC_XWR_RI; dst = `ECA_K_XD; src = `ECA_K_ACC; end
      8'hB2, 8'hC2, 8'hD2:
      begin
        len = 2'h2;
        cyc = `ECA_CYC_BIT;
        dst = `ECA_K_BIT;
        src = `ECA_K_IMM;
        fn = (opc[7:4] == 4'hB) ? `ECA_F_CPLB :
             (opc[7:4] == 4'hC) ? `ECA_F_CLRB : `ECA_F_SETB;
      end
      8'hB3: fn = `ECA_F_CPLC;
      8'hC3: fn = `ECA_F_CLRC;
      8'hD3: fn = `ECA_F_SETC;
      default:
      begin
        if ((opc[7:4] == 4'h2 || opc[7:4] == 4'h3 || opc[7:4] == 4'h9 ||
             opc[7:4] == 4'h4 || opc[7:4] == 4'h5 || opc[7:4] == 4'h6 ||
             opc[7:4] == 4'hE) && opc[3:0] >= 4'h4)
        begin
          // Column picks the source form
          dst = `ECA_K_ACC;
          fn = eca_row_fn(opc[7:4]);
          if (opc[3])
          begin
            src = `ECA_K_REG;
            cyc = `ECA_CYC_REG;
          end
          else if (opc[3:1] == 3'h3)
          begin
            src = `ECA_K_IND;
            cyc = `ECA_CYC_IND;
          end
          else
          begin
            len = 2'h2;
            src = opc[0] ? `ECA_K_DIR : `ECA_K_IMM;
            cyc = opc[0] ? `ECA_CYC_DIR : `ECA_CYC_IMM;
          end
        end
        else if (opc[3] && (opc[7:4] == 4'h0 || opc[7:4] == 4'h1))
        begin
          cyc = `ECA_CYC_INC_REG;
          dst = `ECA_K_REG;
          fn = opc[4] ? `ECA_F_DEC : `ECA_F_INC;
        end
        else if (opc[3] && opc[7:4] == 4'h7)
        begin
          len = 2'h2;
          cyc = `ECA_CYC_IMM;
          dst = `ECA_K_REG;
          src = `ECA_K_IMM;
        end
        else if (opc[3] && opc[7:4] == 4'hF)
        begin
          dst = `ECA_K_REG;
          src = `ECA_K_ACC;
        end
        else
          known = 1'b0;  // Runs as a one-cycle no-op
      end
    endcase
  end

  // Operand values for the ALU
  always @*
  begin
    case (src)
      `ECA_K_ACC: y = ACC;
      `ECA_K_B: y = B_REG;
      `ECA_K_IMM: y = arg1;
      `ECA_K_IMM2: y = arg2;
      `ECA_K_XD: y = XD_RDATA;
      `ECA_K_PM: y = PM_DATA;
      default: y = s_byte;
    endcase
    x = (dst == `ECA_K_ACC) ? ACC : d_byte;
  end

  eca_alu u_alu
  (
    .fn(fn),
    .x(x),
    .y(y),
    .cin(psw_q[`ECA_PSW_CY]),
    .acin(psw_q[`ECA_PSW_AC]),
    .res(alu_res),
    .res_hi(alu_hi),
    .cy(alu_cy),
    .ac(alu_ac),
    .ov(alu_ov),
    .wr_cy(wr_cy),
    .wr_acov(wr_acov)
  );

  // Sequencer: fetch bytes, count cycles, commit on the last one
  always @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      cnt <= 3'h1;
      PC <= `ECA_RST_PC;
      ACC <= `ECA_RST_BYTE;
      B_REG <= `ECA_RST_BYTE;
      psw_q <= `ECA_RST_PSW;
      DATA_POINTER_REGISTER <= `ECA_RST_DATA_POINTER_REGISTER;
      opc_q <= `ECA_RST_BYTE;
      arg1_q <= `ECA_RST_BYTE;
      arg2_q <= `ECA_RST_BYTE;
      XD_ADDR <= `ECA_RST_DATA_POINTER_REGISTER;
      XD_RD <= 1'b0;
      XD_WE <= 1'b0;
      XD_WDATA <= `ECA_RST_BYTE;
      INSTR_DONE <= 1'b0;
      BAD_OPCODE <= 1'b0;
    end
    else
    begin
      // One byte per cycle while fetching, program counter steps by one
      if (fetch)
        PC <= PC + 16'h0001;
      if (cnt == 3'h1)
        opc_q <= PM_DATA;
      if (cnt == 3'h2)
        arg1_q <= PM_DATA;
      if (cnt == 3'h3)
        arg2_q <= PM_DATA;
      cnt <= last ? 3'h1 : cnt + 3'h1;
      INSTR_DONE <= last;
      BAD_OPCODE <= last & ~known;
      // External strobe stands through the final cycle, so data meets the commit
      XD_RD <= pre_last && (src == `ECA_K_XD);
      XD_WE <= pre_last && (dst == `ECA_K_XD);
      if (pre_last && (src == `ECA_K_XD || dst == `ECA_K_XD))
      begin
        XD_ADDR <= opc[1] ? {8'h00, ri_val} : DATA_POINTER_REGISTER;
        XD_WDATA <= ACC;
      end
      if (last)
      begin
        // Flags first, so an explicit status write below wins
        if (wr_cy)
          psw_q[`ECA_PSW_CY] <= alu_cy;
        if (wr_acov)
        begin
          psw_q[`ECA_PSW_AC] <= alu_ac;
          psw_q[`ECA_PSW_OV] <= alu_ov;
        end
        if (fn == `ECA_F_MUL || fn == `ECA_F_DIV)
          B_REG <= alu_hi;
        case (dst)
          `ECA_K_NONE, `ECA_K_XD: INSTR_DONE <= 1'b1;
          `ECA_K_ACC: ACC <= alu_res;
          `ECA_K_DATA_POINTER_REGISTER: DATA_POINTER_REGISTER <= (opc == 8'h90) ? {arg1, arg2} : DATA_POINTER_REGISTER + 16'h0001;
          default:
          begin
            if (d_loc[8])
            begin
              // SPECIAL_FUNCTION_REGISTER writes; unmapped SPECIAL_FUNCTION_REGISTER addresses drop the write
              case (d_loc[7:0])
                `ECA_SFR_ACC: ACC <= alu_res;
                `ECA_SFR_B: B_REG <= alu_res;
                `ECA_SFR_PSW: psw_q <= alu_res[7:1];
                `ECA_SFR_DPL: DATA_POINTER_REGISTER[7:0] <= alu_res;
                `ECA_SFR_DPH: DATA_POINTER_REGISTER[15:8] <= alu_res;
                default: INSTR_DONE <= 1'b1;
              endcase
            end
            else
              iram[d_loc[7:0]] <= alu_res;
          end
        endcase
      end
    end
  end

endmodule

// >>> tb/eca_core_sva.sv
// Port-level assertions for the execution core
`timescale 1ns/100ps
module eca_core_sva
(
  input wire CORE_CLK,
  input wire RST,
  input wire [15:0] PM_ADDR,
  input wire [7:0] PM_DATA,
  input wire [15:0] XD_ADDR,
  input wire XD_RD,
  input wire XD_WE,
  input wire [7:0] XD_WDATA,
  input wire [7:0] XD_RDATA,
  input wire [15:0] PC,
  input wire [7:0] ACC,
  input wire [7:0] B_REG,
  input wire [7:0] PSW,
  input wire [15:0] DATA_POINTER_REGISTER,
  input wire INSTR_DONE,
  input wire BAD_OPCODE
);
  // One clock domain, reset disables everything
  default clocking dck @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  rd_end_a:
    assert property (XD_RD |=> !XD_RD && INSTR_DONE) else $error("read strobe not last cycle");
  we_end_a:
    assert property (XD_WE |=> !XD_WE && INSTR_DONE) else $error("write strobe not last cycle");
  rd_acc_a:
    assert property (XD_RD |=> ACC == $past(XD_RDATA)) else $error("read data not in acc");
  wr_data_a:
    assert property (XD_WE |-> XD_WDATA == ACC) else $error("write data is not acc");
  bad_pc_a:
    assert property (BAD_OPCODE |-> INSTR_DONE && PC == $past(PC) + 16'h0001)
      else $error("unknown opcode not one byte");
  table_addr_a:
    assert property (INSTR_DONE && PM_DATA == 8'h93 |=> PM_ADDR == DATA_POINTER_REGISTER + {8'h00, ACC})
      else $error("table read address wrong");
  ptr_inc_a:
    assert property (INSTR_DONE && PM_DATA == 8'hA3 |=> INSTR_DONE && DATA_POINTER_REGISTER == $past(DATA_POINTER_REGISTER) + 16'h0001)
      else $error("pointer increment wrong");
  nib_swap_a:
    assert property (INSTR_DONE && PM_DATA == 8'hC4 |=>
      INSTR_DONE && ACC == (($past(ACC) << 4) | ($past(ACC) >> 4))) else $error("swap wrong");
  div_time_a:
    assert property (INSTR_DONE && PM_DATA == 8'h84 |=> !INSTR_DONE [*5] ##1 INSTR_DONE)
      else $error("divide not six cycles");
endmodule

// >>> tb/eca_mem_model.sv
// Program memory and external data model facing the execution core
`timescale 1ns/100ps
module eca_mem_model
(
  input wire clk,
  input wire [15:0] pm_addr,
  output wire [7:0] pm_data,
  input wire [15:0] xd_addr,
  input wire xd_rd,
  input wire xd_we,
  input wire [7:0] xd_wdata,
  output wire [7:0] xd_rdata
);
  // Code store loaded by the bench; only 256 bytes, upper address bits alias
  logic [7:0] pm [0:255];
  // External data store
  logic [7:0] xd [0:255];
  // Last byte returned, inverted while idle so stale data never looks valid
  logic [7:0] last = 8'h00;
  initial foreach (pm[i]) pm[i] = 8'h00;
  // Asynchronous code read, no wait states
  assign pm_data = pm[pm_addr[7:0]];
  // Read data valid only while the strobe stands
  assign xd_rdata = xd_rd ? xd[xd_addr[7:0]] : ~last;
  // Writes land on the edge that ends the strobe cycle
  always @(posedge clk)
  begin
    if (xd_we)
      xd[xd_addr[7:0]] <= xd_wdata;
    if (xd_rd)
      last <= xd_rdata;
  end
endmodule

// >>> tb/eight_bit_cpu_alu_addressing_tb_top.sv
// Self-checking bench running a short program through the execution core
`timescale 1ns/100ps
module eight_bit_cpu_alu_addressing_tb_top;
  logic CORE_CLK = 1'b0; // 100 MHz
  logic RST = 1'b1; // Held from time zero
  wire [15:0] PM_ADDR, XD_ADDR, PC, DATA_POINTER_REGISTER;
  wire [7:0] PM_DATA, XD_WDATA, XD_RDATA, ACC, B_REG, PSW;
  wire XD_RD, XD_WE, INSTR_DONE, BAD_OPCODE;
  int bad_count = 0;
  int comparisons = 0;
  int lp = 0; // Next free code address
  eca_core dut (.CORE_CLK(CORE_CLK), .RST(RST), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA),
    .XD_ADDR(XD_ADDR), .XD_RD(XD_RD), .XD_WE(XD_WE), .XD_WDATA(XD_WDATA),
    .XD_RDATA(XD_RDATA), .PC(PC), .ACC(ACC), .B_REG(B_REG), .PSW(PSW), .DATA_POINTER_REGISTER(DATA_POINTER_REGISTER),
    .INSTR_DONE(INSTR_DONE), .BAD_OPCODE(BAD_OPCODE));
  eca_mem_model mem (.clk(CORE_CLK), .pm_addr(PM_ADDR), .pm_data(PM_DATA),
    .xd_addr(XD_ADDR), .xd_rd(XD_RD), .xd_we(XD_WE), .xd_wdata(XD_WDATA),
    .xd_rdata(XD_RDATA));
  initial forever #5 CORE_CLK = ~CORE_CLK;
  // Verdict and end of run
  task wrap_up;
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Compare one value, four-state exact
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Place code bytes; written while the opcode fetch cycle runs, before its edge
  task put(input logic [7:0] b0, b1, b2, input int len);
    mem.pm[lp] = b0;
    mem.pm[lp + 1] = b1;
    mem.pm[lp + 2] = b2;
    lp = lp + len;
  endtask
  // Count cycles to the done pulse, then judge timing, acc and fetch position
  task step(input int cyc, input logic [7:0] acc);
    int n;
    n = 0;
    do
    begin
      @(posedge CORE_CLK);
      #1;
      n++;
    end
    while (INSTR_DONE !== 1'b1 && n < 12);
    chk("cycles", 16'(cyc), 16'(n));
    chk("acc", {8'h00, acc}, {8'h00, ACC});
    chk("pc", 16'(lp), PC);
  endtask
  task ins(input logic [7:0] b0, b1, b2, input int len, cyc, input logic [7:0] acc);
    put(b0, b1, b2, len);
    step(cyc, acc);
  endtask
  // Reset state, then the first opcode fetched from address zero
  task t_reset;
    chk("pc", 16'h0000, PC);
    chk("data_pointer_register", 16'h0000, DATA_POINTER_REGISTER);
    chk("acc_b", 16'h0000, {ACC, B_REG});
    put(8'hE4, 8'h00, 8'h00, 1);
    RST = 1'b0;
    step(1, 8'h00);
  endtask
  // Immediate operands with carry and borrow chains
  task t_arith;
    ins(8'h74, 8'h5A, 8'h00, 2, 2, 8'h5A);
    ins(8'h24, 8'hA7, 8'h00, 2, 2, 8'h01);
    chk("cy", 16'h0001, {15'h0, PSW[7]});
    ins(8'h34, 8'h10, 8'h00, 2, 2, 8'h12);
    ins(8'h94, 8'h13, 8'h00, 2, 2, 8'hFF);
    chk("cy", 16'h0001, {15'h0, PSW[7]});
    ins(8'h94, 8'h00, 8'h00, 2, 2, 8'hFE);
  endtask
  // Accumulator unary and bytewise logic
  task t_logic;
    ins(8'hC4, 8'h00, 8'h00, 1, 1, 8'hEF);
    ins(8'hF4, 8'h00, 8'h00, 1, 1, 8'h10);
    ins(8'h64, 8'h5C, 8'h00, 2, 2, 8'h4C);
    ins(8'h44, 8'h03, 8'h00, 2, 2, 8'h4F);
    ins(8'h54, 8'hC6, 8'h00, 2, 2, 8'h46);
  endtask
  // Register, direct and indirect operands
  task t_modes;
    ins(8'h75, 8'h00, 8'h46, 3, 3, 8'h46);
    ins(8'hE4, 8'h00, 8'h00, 1, 1, 8'h00);
    ins(8'h28, 8'h00, 8'h00, 1, 1, 8'h46);
    ins(8'h75, 8'h30, 8'h46, 3, 3, 8'h46);
    ins(8'h05, 8'h30, 8'h00, 2, 3, 8'h46);
    ins(8'h75, 8'h00, 8'h30, 3, 3, 8'h46);
    ins(8'h26, 8'h00, 8'h00, 1, 2, 8'h8D);
    ins(8'h04, 8'h00, 8'h00, 1, 1, 8'h8E);
    ins(8'h18, 8'h00, 8'h00, 1, 2, 8'h8E);
    ins(8'hE8, 8'h00, 8'h00, 1, 1, 8'h2F);
  endtask
  // Multiply, divide, logic into a direct byte
  task t_muldiv;
    ins(8'h75, 8'hF0, 8'h07, 3, 3, 8'h2F);
    ins(8'hA4, 8'h00, 8'h00, 1, 2, 8'h49);
    chk("b", 16'h0001, {8'h00, B_REG});
    ins(8'h84, 8'h00, 8'h00, 1, 6, 8'h49);
    chk("b", 16'h0000, {8'h00, B_REG});
    ins(8'h62, 8'h30, 8'h00, 2, 3, 8'h49);
    ins(8'hE5, 8'h30, 8'h00, 2, 2, 8'h0E);
  endtask
  // Table read, pointer increment, external data, unknown opcode
  task t_tables;
    mem.pm[8'h42] = 8'h3C;
    ins(8'h90, 8'h00, 8'h40, 3, 3, 8'h0E);
    ins(8'h74, 8'h02, 8'h00, 2, 2, 8'h02);
    ins(8'h93, 8'h00, 8'h00, 1, 5, 8'h3C);
    ins(8'hA3, 8'h00, 8'h00, 1, 1, 8'h3C);
    chk("data_pointer_register", 16'h0041, DATA_POINTER_REGISTER);
    ins(8'hF0, 8'h00, 8'h00, 1, 4, 8'h3C);
    chk("xdata", 16'h003C, {8'h00, mem.xd[8'h41]});
    ins(8'hE4, 8'h00, 8'h00, 1, 1, 8'h00);
    ins(8'hE0, 8'h00, 8'h00, 1, 3, 8'h3C);
    ins(8'hA5, 8'h00, 8'h00, 1, 1, 8'h3C);
    chk("bad", 16'h0001, {15'h0, BAD_OPCODE});
    // Bit 3 of the bit space lives in RAM byte 20h; clear it first, then set one bit
    ins(8'h75, 8'h20, 8'h00, 3, 3, 8'h3C);
    ins(8'hD2, 8'h03, 8'h00, 2, 3, 8'h3C);
    ins(8'hE5, 8'h20, 8'h00, 2, 2, 8'h08);
  endtask
  // Reset for 8 cycles, then the scenarios in program order
  initial
  begin
    repeat (8) @(posedge CORE_CLK);
    #1;
    t_reset();
    t_arith();
    t_logic();
    t_modes();
    t_muldiv();
    t_tables();
    wrap_up();
  end
  // Watchdog: the program needs well under 2000 cycles
  initial
  begin
    #20000;
    bad_count++;
    wrap_up();
  end
endmodule
bind eca_core eca_core_sva chk_i (.CORE_CLK(CORE_CLK), .RST(RST), .PM_ADDR(PM_ADDR),
  .PM_DATA(PM_DATA), .XD_ADDR(XD_ADDR), .XD_RD(XD_RD), .XD_WE(XD_WE), .XD_WDATA(XD_WDATA),
  .XD_RDATA(XD_RDATA), .PC(PC), .ACC(ACC), .B_REG(B_REG), .PSW(PSW), .DATA_POINTER_REGISTER(DATA_POINTER_REGISTER),
  .INSTR_DONE(INSTR_DONE), .BAD_OPCODE(BAD_OPCODE));
